// >>> logic/rsc_capture_station.sv
// capture station: records receiver test buses into memory on a selected trigger
//
// Summary of operation
// - up to four buses, two at full rate
// - configure sets rate, trigger and signals
// - armed station waits for the trigger
// - readout returns stored capture after trigger
// - readout without capture returns an error
// - one capture per arming, then reconfigure
// - occurrence count N captures Nth event
// - transmit-active falling edge, delay, post recording
// - receive-error rising edge with pre-trigger history
// - only real receive errors trigger, not timeouts
// - 8-bit buses, sign placeable in one byte
// - raw ADC channels are 10-bit signed
// - filtered channels are 15-bit signed
// - matched and sync outputs are 15-bit signed
// - decoder state field observed on status
// - slower rate stretches capture time span
module rsc_capture_station #(
   parameter int DEPTH = 2048,
   parameter int NBUS = 4
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic arst_n_in,
   // wishbone slave
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   // receiver test signals
   input wire logic [9:0] adc_i_in,
   input wire logic [9:0] adc_q_in,
   input wire logic [14:0] filt_i_in,
   input wire logic [14:0] filt_q_in,
   input wire logic [14:0] matched_out_zero_in,
   input wire logic [14:0] matched_out_one_in,
   input wire logic [14:0] sync_filter_result_in,
   // observation buses
   input wire logic [7:0] tx_encoder_observe_bus_in,
   input wire logic [7:0] patch_observe_bus_in,
   input wire logic [7:0] rx_decoder_observe_bus_a_in,
   input wire logic [7:0] rx_decoder_observe_bus_b_in,
   // interrupt
   output logic irq_out
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW-1:0] LAST_ADDR = AW'(DEPTH - 1);

   ////////////////////////////////////////////////////////////////////////////
   // bus decode
   logic ack_reg;
   logic req;
   logic wr;
   logic rd;
   logic [31:0] wmask;
   assign req = wb_cyc_in & wb_stb_in & ~ack_reg;
   assign wr = req & wb_we_in;
   assign rd = req & ~wb_we_in;
   assign wmask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                         input logic [31:0] m);
      merge = (old & ~m) | (dat & m);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // configuration registers
   rsc_pkg::rsc_state_t state_reg;
   logic [rsc_pkg::CFG_W-1:0] cfg_reg;
   logic [NBUS*rsc_pkg::SEL_FIELD_W-1:0] sel_reg;
   logic [rsc_pkg::OCCUR_W-1:0] occur_reg;
   logic [rsc_pkg::DELAY_W-1:0] delay_reg;
   logic [rsc_pkg::INT_W-1:0] int_mask_reg;
   logic cfg_open;

   // settings except the interrupt mask are frozen while a capture is in progress
   assign cfg_open = (state_reg == rsc_pkg::ST_IDLE) || (state_reg == rsc_pkg::ST_DONE);

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cfg_reg <= rsc_pkg::CFG_RESET;
         sel_reg <= '0;
         occur_reg <= '0;
         delay_reg <= '0;
         int_mask_reg <= '0;
      end else if (wr) begin
         unique case (wb_adr_in)
            rsc_pkg::REG_CFG: if (cfg_open) begin
               cfg_reg <= rsc_pkg::CFG_W'(merge(32'(cfg_reg), wb_dat_in, wmask));
            end
            rsc_pkg::REG_SEL: if (cfg_open) begin
               sel_reg <= (NBUS*rsc_pkg::SEL_FIELD_W)'(merge(32'(sel_reg), wb_dat_in, wmask));
            end
            rsc_pkg::REG_OCCUR: if (cfg_open) begin
               occur_reg <= rsc_pkg::OCCUR_W'(merge(32'(occur_reg), wb_dat_in, wmask));
            end
            rsc_pkg::REG_DELAY: if (cfg_open) begin
               delay_reg <= rsc_pkg::DELAY_W'(merge(32'(delay_reg), wb_dat_in, wmask));
            end
            rsc_pkg::REG_INT_MASK: begin
               int_mask_reg <= rsc_pkg::INT_W'(merge(32'(int_mask_reg), wb_dat_in, wmask));
            end
            default: begin
            end
         endcase
      end
   end

   logic [2:0] rate;
   logic trig_rx;
   logic pre_mode;
   logic [2:0] nbus_req;
   logic [2:0] nbus_eff;
   assign rate = (cfg_reg[rsc_pkg::CFG_RATE_LSB +: rsc_pkg::CFG_RATE_W] > rsc_pkg::RATE_MAX)
                 ? rsc_pkg::RATE_MAX : cfg_reg[rsc_pkg::CFG_RATE_LSB +: rsc_pkg::CFG_RATE_W];
   assign trig_rx = cfg_reg[rsc_pkg::CFG_TRIG_SRC];
   assign pre_mode = cfg_reg[rsc_pkg::CFG_PRE_MODE];
   assign nbus_req = 3'(cfg_reg[rsc_pkg::CFG_NBUS_LSB +: rsc_pkg::CFG_NBUS_W]) + 3'h1;
   // the full rate has bandwidth for two buses only
   assign nbus_eff = (rate == rsc_pkg::RATE_FULL && nbus_req > rsc_pkg::FULL_RATE_BUSES)
                     ? rsc_pkg::FULL_RATE_BUSES : nbus_req;

   ////////////////////////////////////////////////////////////////////////////
   // sample rate divider
   logic [4:0] div_cnt;
   logic [4:0] div_mask;
   logic sample_en;
   assign div_mask = 5'((6'h01 << rate) - 6'h01);
   assign sample_en = (div_cnt & div_mask) == 5'h00;

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         div_cnt <= 5'h00;
      end else begin
         div_cnt <= div_cnt + 5'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // test signal formatting and bus selection
   logic [15:0] sig_ext [rsc_pkg::NSIG];
   logic [7:0] sig_top [rsc_pkg::NSIG];
   always_comb begin
      // signed samples extended to 16 bits, top byte keeps the sign bit
      sig_ext[rsc_pkg::SIG_ADC_I] = 16'($signed(adc_i_in));
      sig_ext[rsc_pkg::SIG_ADC_Q] = 16'($signed(adc_q_in));
      sig_ext[rsc_pkg::SIG_FILT_I] = 16'($signed(filt_i_in));
      sig_ext[rsc_pkg::SIG_FILT_Q] = 16'($signed(filt_q_in));
      sig_ext[rsc_pkg::SIG_MATCHED_ZERO] = 16'($signed(matched_out_zero_in));
      sig_ext[rsc_pkg::SIG_MATCHED_ONE] = 16'($signed(matched_out_one_in));
      sig_ext[rsc_pkg::SIG_SYNC] = 16'($signed(sync_filter_result_in));
      sig_ext[rsc_pkg::SIG_TX_ENC] = {8'h00, tx_encoder_observe_bus_in};
      sig_ext[rsc_pkg::SIG_PATCH] = {8'h00, patch_observe_bus_in};
      sig_ext[rsc_pkg::SIG_RXDEC_A] = {8'h00, rx_decoder_observe_bus_a_in};
      sig_ext[rsc_pkg::SIG_RXDEC_B] = {8'h00, rx_decoder_observe_bus_b_in};
      sig_top[rsc_pkg::SIG_ADC_I] = adc_i_in[rsc_pkg::ADC_W-1 -: 8];
      sig_top[rsc_pkg::SIG_ADC_Q] = adc_q_in[rsc_pkg::ADC_W-1 -: 8];
      sig_top[rsc_pkg::SIG_FILT_I] = filt_i_in[rsc_pkg::FILT_W-1 -: 8];
      sig_top[rsc_pkg::SIG_FILT_Q] = filt_q_in[rsc_pkg::FILT_W-1 -: 8];
      sig_top[rsc_pkg::SIG_MATCHED_ZERO] = matched_out_zero_in[rsc_pkg::FILT_W-1 -: 8];
      sig_top[rsc_pkg::SIG_MATCHED_ONE] = matched_out_one_in[rsc_pkg::FILT_W-1 -: 8];
      sig_top[rsc_pkg::SIG_SYNC] = sync_filter_result_in[rsc_pkg::FILT_W-1 -: 8];
      sig_top[rsc_pkg::SIG_TX_ENC] = tx_encoder_observe_bus_in;
      sig_top[rsc_pkg::SIG_PATCH] = patch_observe_bus_in;
      sig_top[rsc_pkg::SIG_RXDEC_A] = rx_decoder_observe_bus_a_in;
      sig_top[rsc_pkg::SIG_RXDEC_B] = rx_decoder_observe_bus_b_in;
   end

   logic [NBUS*8-1:0] sample_word;
   genvar b;
   generate
      for (b = 0; b < NBUS; b++) begin : g_bus
         logic [rsc_pkg::SEL_FIELD_W-1:0] field;
         logic [rsc_pkg::SEL_IDX_W-1:0] idx;
         logic [1:0] mode;
         logic [7:0] lane;
         assign field = sel_reg[b*rsc_pkg::SEL_FIELD_W +: rsc_pkg::SEL_FIELD_W];
         assign idx = field[rsc_pkg::SEL_IDX_W-1:0];
         assign mode = field[rsc_pkg::SEL_FIELD_W-1 -: 2];
         always_comb begin
            if (32'(idx) >= rsc_pkg::NSIG || 32'(b) >= 32'(nbus_eff)) begin
               lane = 8'h00;
            end else if (mode == rsc_pkg::BYTE_TOP) begin
               lane = sig_top[idx];
            end else if (mode == rsc_pkg::BYTE_HIGH) begin
               lane = sig_ext[idx][15:8];
            end else begin
               lane = sig_ext[idx][7:0];
            end
         end
         assign sample_word[b*8 +: 8] = lane;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // trigger detection
   logic tx_active_d_reg;
   logic rx_error_d_reg;
   logic trig_ev;
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         tx_active_d_reg <= 1'b0;
         rx_error_d_reg <= 1'b0;
      end else begin
         tx_active_d_reg <= tx_encoder_observe_bus_in[rsc_pkg::TX_ACTIVE_BIT];
         rx_error_d_reg <= patch_observe_bus_in[rsc_pkg::RX_ERROR_BIT];
      end
   end
   // the error bit is raised by the decoder only; a response timeout never sets it
   assign trig_ev = trig_rx
      ? (patch_observe_bus_in[rsc_pkg::RX_ERROR_BIT] & ~rx_error_d_reg)
      : (~tx_encoder_observe_bus_in[rsc_pkg::TX_ACTIVE_BIT] & tx_active_d_reg);

   ////////////////////////////////////////////////////////////////////////////
   // capture sequencer
   logic [AW-1:0] wr_ptr;
   logic wrapped;
   logic [rsc_pkg::DELAY_W-1:0] dly_cnt;
   logic [rsc_pkg::OCCUR_W-1:0] occ_cnt;
   logic [rsc_pkg::OCCUR_W-1:0] occ_target;
   logic configured;
   logic captured;
   logic cmd_cfg;
   logic cmd_arm;
   logic arm_reject;
   logic fire;
   logic mem_we;

   assign cmd_cfg = wr && wb_adr_in == rsc_pkg::REG_CMD && wb_sel_in[0]
                    && wb_dat_in[rsc_pkg::CMD_CONFIGURE];
   assign cmd_arm = wr && wb_adr_in == rsc_pkg::REG_CMD && wb_sel_in[0]
                    && wb_dat_in[rsc_pkg::CMD_ARM] && !cmd_cfg;
   // arming needs a fresh configure and a quiet station
   assign arm_reject = cmd_arm && !(configured && state_reg == rsc_pkg::ST_IDLE);
   // a count of zero behaves as one
   assign occ_target = (occur_reg == '0) ? rsc_pkg::OCCUR_W'(1) : occur_reg;
   assign fire = state_reg == rsc_pkg::ST_ARMED && trig_ev
                 && (occ_cnt + rsc_pkg::OCCUR_W'(1)) >= occ_target;
   assign mem_we = sample_en && (state_reg == rsc_pkg::ST_POST
                   || (state_reg == rsc_pkg::ST_ARMED && pre_mode && !fire));

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_reg <= rsc_pkg::ST_IDLE;
         wr_ptr <= '0;
         wrapped <= 1'b0;
         dly_cnt <= '0;
         occ_cnt <= '0;
         configured <= 1'b0;
         captured <= 1'b0;
      end else begin
         if (mem_we) begin
            wr_ptr <= wr_ptr + AW'(1);
            if (wr_ptr == LAST_ADDR) begin
               wrapped <= 1'b1;
            end
         end
         unique case (state_reg)
            rsc_pkg::ST_IDLE, rsc_pkg::ST_DONE: begin
               if (cmd_cfg && cfg_open) begin
                  configured <= 1'b1;
                  captured <= 1'b0;
                  state_reg <= rsc_pkg::ST_IDLE;
               end else if (cmd_arm && !arm_reject) begin
                  configured <= 1'b0;
                  wr_ptr <= '0;
                  wrapped <= 1'b0;
                  occ_cnt <= '0;
                  state_reg <= rsc_pkg::ST_ARMED;
               end
            end
            rsc_pkg::ST_ARMED: begin
               if (fire) begin
                  if (pre_mode) begin
                     captured <= 1'b1;
                     state_reg <= rsc_pkg::ST_DONE;
                  end else if (delay_reg == '0) begin
                     state_reg <= rsc_pkg::ST_POST;
                  end else begin
                     dly_cnt <= delay_reg;
                     state_reg <= rsc_pkg::ST_DELAY;
                  end
               end else if (trig_ev) begin
                  occ_cnt <= occ_cnt + rsc_pkg::OCCUR_W'(1);
               end
            end
            rsc_pkg::ST_DELAY: begin
               // the delay counts sample ticks, so it scales with the rate
               if (sample_en) begin
                  dly_cnt <= dly_cnt - rsc_pkg::DELAY_W'(1);
                  if (dly_cnt == rsc_pkg::DELAY_W'(1)) begin
                     state_reg <= rsc_pkg::ST_POST;
                  end
               end
            end
            rsc_pkg::ST_POST: begin
               if (mem_we && wr_ptr == LAST_ADDR) begin
                  captured <= 1'b1;
                  state_reg <= rsc_pkg::ST_DONE;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // capture memory
   logic [NBUS*8-1:0] mem [DEPTH];
   always_ff @(posedge clk_in) begin
      if (mem_we) begin
         mem[wr_ptr] <= sample_word;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // readout pointer
   logic [AW-1:0] rd_ptr;
   logic [AW-1:0] rd_base;
   logic rd_data_req;
   logic read_err;
   // after a circular capture the oldest sample sits at the write pointer
   assign rd_base = (pre_mode && wrapped) ? wr_ptr : '0;
   assign rd_data_req = rd && wb_adr_in == rsc_pkg::REG_RD_DATA;
   assign read_err = rd_data_req && !captured;

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rd_ptr <= '0;
      end else if (wr && wb_adr_in == rsc_pkg::REG_RD_PTR) begin
         rd_ptr <= wb_dat_in[AW-1:0];
      end else if (cmd_arm && !arm_reject) begin
         rd_ptr <= '0;
      end else if (rd_data_req && captured) begin
         rd_ptr <= rd_ptr + AW'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupts
   logic [rsc_pkg::INT_W-1:0] int_stat_reg;
   logic [rsc_pkg::INT_W-1:0] int_ev;
   logic int_clr;
   always_comb begin
      int_ev = '0;
      int_ev[rsc_pkg::INT_DONE] = (state_reg != rsc_pkg::ST_DONE) && (fire && pre_mode
         || state_reg == rsc_pkg::ST_POST && mem_we && wr_ptr == LAST_ADDR);
      int_ev[rsc_pkg::INT_ARM_REJECT] = arm_reject;
      int_ev[rsc_pkg::INT_READ_ERR] = read_err;
   end
   assign int_clr = rd && wb_adr_in == rsc_pkg::REG_INT_STAT;

   // a new event in the clearing cycle survives the clear
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         int_stat_reg <= '0;
      end else begin
         int_stat_reg <= (int_clr ? '0 : int_stat_reg) | int_ev;
      end
   end
   assign irq_out = |(int_stat_reg & int_mask_reg);

   ////////////////////////////////////////////////////////////////////////////
   // read mux and acknowledge
   logic [31:0] rdata;
   always_comb begin
      rdata = 32'h0000_0000;
      unique case (wb_adr_in)
         rsc_pkg::REG_CFG: rdata = 32'(cfg_reg);
         rsc_pkg::REG_SEL: rdata = 32'(sel_reg);
         rsc_pkg::REG_OCCUR: rdata = 32'(occur_reg);
         rsc_pkg::REG_DELAY: rdata = 32'(delay_reg);
         rsc_pkg::REG_STATUS: begin
            rdata[4:0] = state_reg;
            rdata[5] = configured;
            rdata[6] = captured;
            rdata[7] = wrapped;
            // receiver decoder state: 0 idle, 1 rx active, 2 after first start bit
            rdata[9:8] = rx_decoder_observe_bus_a_in[rsc_pkg::DEC_STATE_LSB +: 2];
            rdata[10 +: rsc_pkg::OCCUR_W] = occ_cnt;
            rdata[31 -: 3] = nbus_eff;
         end
         rsc_pkg::REG_INT_STAT: rdata = 32'(int_stat_reg);
         rsc_pkg::REG_INT_MASK: rdata = 32'(int_mask_reg);
         rsc_pkg::REG_RD_PTR: rdata = 32'(rd_ptr);
         rsc_pkg::REG_RD_DATA: begin
            rdata = captured ? 32'(mem[rd_base + rd_ptr])
                             : rsc_pkg::READ_ERROR_WORD;
         end
         default: rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ack_reg <= 1'b0;
         wb_dat_out <= 32'h0000_0000;
      end else begin
         ack_reg <= req;
         if (rd) begin
            wb_dat_out <= rdata;
         end
      end
   end
   assign wb_ack_out = ack_reg;

endmodule // rsc_capture_station

// >>> logic/rsc_pkg.sv
// package: register map, field layout, states and constants of the capture station
package rsc_pkg;
   // register byte offsets
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_CFG = 8'h04;
   localparam logic [7:0] REG_SEL = 8'h08;
   localparam logic [7:0] REG_OCCUR = 8'h0C;
   localparam logic [7:0] REG_DELAY = 8'h10;
   localparam logic [7:0] REG_STATUS = 8'h14;
   localparam logic [7:0] REG_INT_STAT = 8'h18;
   localparam logic [7:0] REG_INT_MASK = 8'h1C;
   localparam logic [7:0] REG_RD_PTR = 8'h20;
   localparam logic [7:0] REG_RD_DATA = 8'h24;

   // command bits
   localparam int CMD_CONFIGURE = 0;
   localparam int CMD_ARM = 1;

   // configuration fields
   localparam int CFG_RATE_LSB = 0;
   localparam int CFG_RATE_W = 3;
   localparam int CFG_TRIG_SRC = 4;
   localparam int CFG_PRE_MODE = 5;
   localparam int CFG_NBUS_LSB = 8;
   localparam int CFG_NBUS_W = 2;
   localparam int CFG_W = 10;
   localparam logic [CFG_W-1:0] CFG_RESET = 10'h000;

   // rate codes: sample every 2**code clocks, code 0 is the full rate, codes above 4 act as code 4
   localparam logic [2:0] RATE_FULL = 3'h0;
   localparam logic [2:0] RATE_MAX = 3'h4;
   localparam logic [2:0] FULL_RATE_BUSES = 3'h2;

   // bus selector: per bus a 6-bit field
   localparam int SEL_FIELD_W = 6;
   localparam int SEL_IDX_W = 4;
   localparam logic [1:0] BYTE_LOW = 2'h0;
   localparam logic [1:0] BYTE_HIGH = 2'h1;
   localparam logic [1:0] BYTE_TOP = 2'h2;

   // selectable test signals
   localparam int NSIG = 11;
   localparam logic [3:0] SIG_ADC_I = 4'h0;
   localparam logic [3:0] SIG_ADC_Q = 4'h1;
   localparam logic [3:0] SIG_FILT_I = 4'h2;
   localparam logic [3:0] SIG_FILT_Q = 4'h3;
   localparam logic [3:0] SIG_MATCHED_ZERO = 4'h4;
   localparam logic [3:0] SIG_MATCHED_ONE = 4'h5;
   localparam logic [3:0] SIG_SYNC = 4'h6;
   localparam logic [3:0] SIG_TX_ENC = 4'h7;
   localparam logic [3:0] SIG_PATCH = 4'h8;
   localparam logic [3:0] SIG_RXDEC_A = 4'h9;
   localparam logic [3:0] SIG_RXDEC_B = 4'hA;
   localparam int ADC_W = 10;
   localparam int FILT_W = 15;

   // observation bits
   localparam int TX_ACTIVE_BIT = 4;
   localparam int RX_ERROR_BIT = 4;
   localparam int DEC_STATE_LSB = 0;

   // interrupt status bits
   localparam int INT_W = 3;
   localparam int INT_DONE = 0;
   localparam int INT_ARM_REJECT = 1;
   localparam int INT_READ_ERR = 2;

   localparam int OCCUR_W = 8;
   localparam int DELAY_W = 16;
   localparam logic [31:0] READ_ERROR_WORD = 32'hEEEE_EEEE;

   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_ARMED = 5'b00010,
      ST_DELAY = 5'b00100,
      ST_POST = 5'b01000,
      ST_DONE = 5'b10000
   } rsc_state_t;
endpackage : rsc_pkg

// >>> test/rsc_capture_station_test.sv
// testbench: command sequences against the capture station with expected values
module rsc_capture_station_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int DEPTH = 16;
   logic clk_in, cyc, stb, we, ack, irq;
   logic arst_n_in = 1'b0;
   logic [7:0] adr;
   logic [7:0] tx_bus = 8'h00;
   logic [7:0] patch_bus = 8'h00;
   logic [7:0] deca_bus = 8'h00;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, got;
   logic [9:0] adc_i = 10'h2C4;
   logic [14:0] filt_i = 15'h4ABC;
   int error_cnt = 0;
   int tests_run = 0;
   rsc_capture_station #(.DEPTH(DEPTH), .NBUS(4)) dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
      .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
      .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .adc_i_in(adc_i),
      .adc_q_in(adc_i), .filt_i_in(filt_i), .filt_q_in(filt_i), .matched_out_zero_in(filt_i),
      .matched_out_one_in(filt_i), .sync_filter_result_in(filt_i),
      .tx_encoder_observe_bus_in(tx_bus), .patch_observe_bus_in(patch_bus),
      .rx_decoder_observe_bus_a_in(deca_bus), .rx_decoder_observe_bus_b_in(deca_bus),
      .irq_out(irq));
   rsc_host_model host (.clk_in(clk_in), .wb_cyc_out(cyc), .wb_stb_out(stb), .wb_we_out(we),
      .wb_adr_out(adr), .wb_sel_out(sel), .wb_dat_out(wdat), .wb_dat_in(rdat), .wb_ack_in(ack));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.access(1'b1, a, d, got);
   endtask
   task automatic rd(input logic [7:0] a);
      host.access(1'b0, a, 32'h0000_0000, got);
   endtask
   task automatic tx_fall;
      @(posedge clk_in);
      tx_bus <= 8'h10;
      @(posedge clk_in);
      tx_bus <= 8'h00;
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end
   initial begin
      repeat (3000) @(posedge clk_in);
      error_cnt++;
      tally_and_finish;
   end
   initial begin
      repeat (3) @(posedge clk_in);
      arst_n_in <= 1'b1;
      rd(rsc_pkg::REG_STATUS);
      chk(got, 32'h2000_0001);
      rd(8'h3C);
      chk(got, 32'h0000_0000);
      $display("test reset done");
      wr(rsc_pkg::REG_CMD, 32'h0000_0002);
      rd(rsc_pkg::REG_RD_DATA);
      chk(got, rsc_pkg::READ_ERROR_WORD);
      wr(rsc_pkg::REG_INT_MASK, 32'h0000_0007);
      @(posedge clk_in);
      chk({31'h0, irq}, 32'h1);
      rd(rsc_pkg::REG_INT_STAT);
      chk(got, 32'h0000_0006);
      @(posedge clk_in);
      chk({31'h0, irq}, 32'h0);
      $display("test refusals done");
      wr(rsc_pkg::REG_CFG, 32'h0000_0201);
      wr(rsc_pkg::REG_SEL, 32'h0001_38A0);
      wr(rsc_pkg::REG_OCCUR, 32'h0000_0002);
      wr(rsc_pkg::REG_DELAY, 32'h0000_0003);
      wr(rsc_pkg::REG_CMD, 32'h0000_0001);
      wr(rsc_pkg::REG_CMD, 32'h0000_0002);
      tx_fall;
      rd(rsc_pkg::REG_STATUS);
      chk(got & 32'h0003_FC1F, 32'h0000_0402);
      tx_fall;
      // two-clock sample period: delay ticks plus twice the depth to fill
      repeat (2 * DEPTH + 16) @(posedge clk_in);
      rd(rsc_pkg::REG_STATUS);
      chk(got & 32'h0000_005F, 32'h0000_0050);
      repeat (DEPTH) begin
         rd(rsc_pkg::REG_RD_DATA);
         chk(got, 32'h00CA_95B1);
      end
      wr(rsc_pkg::REG_CMD, 32'h0000_0002);
      rd(rsc_pkg::REG_INT_STAT);
      chk(got, 32'h0000_0003);
      $display("test post trigger done");
      deca_bus <= 8'h01;
      wr(rsc_pkg::REG_CFG, 32'h0000_0330);
      wr(rsc_pkg::REG_SEL, 32'h0000_0020);
      wr(rsc_pkg::REG_OCCUR, 32'h0000_0001);
      wr(rsc_pkg::REG_CMD, 32'h0000_0001);
      wr(rsc_pkg::REG_CMD, 32'h0000_0002);
      rd(rsc_pkg::REG_STATUS);
      chk(got & 32'hE000_0300, 32'h4000_0100);
      repeat (DEPTH + 4) @(posedge clk_in);
      patch_bus <= 8'h08;
      @(posedge clk_in);
      patch_bus <= 8'h00;
      rd(rsc_pkg::REG_STATUS);
      chk(got & 32'h0000_001F, 32'h0000_0002);
      patch_bus <= 8'h10;
      repeat (2) @(posedge clk_in);
      rd(rsc_pkg::REG_STATUS);
      chk(got & 32'h0000_009F, 32'h0000_0090);
      rd(rsc_pkg::REG_INT_STAT);
      chk(got, 32'h0000_0001);
      rd(rsc_pkg::REG_RD_DATA);
      chk(got, 32'h0000_C4B1);
      $display("test pre trigger done");
      tally_and_finish;
   end
endmodule // rsc_capture_station_test

// >>> test/rsc_checker_assertions.sv
// checker: port-level assertions of the capture station, bound to its top module
module rsc_checker (
   // clock and reset
   input wire logic clk_in,
   input wire logic arst_n_in,
   // wishbone
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic wb_ack_out,
   // observation and interrupt
   input wire logic [7:0] rx_decoder_observe_bus_a_in,
   input wire logic irq_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic rd_stat;
   logic [1:0] dec_now;
   // the address is still held in the ack cycle, so status reads are seen there
   assign rd_stat = wb_ack_out && !wb_we_in && wb_adr_in == rsc_pkg::REG_STATUS;
   assign dec_now = rx_decoder_observe_bus_a_in[1:0];
   default clocking @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   ////////////////////////////////////////////////////////////////////////////////
   AST_ACK_TAKEN: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
      else $error("request not acknowledged one cycle after it was taken");
   AST_ACK_PULSE: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("acknowledge lasted more than one cycle");
   AST_NO_SPUR: assert property (!(wb_cyc_in && wb_stb_in) |=> !wb_ack_out)
      else $error("acknowledge without a request");
   AST_BUS_LIMIT: assert property (rd_stat |-> wb_dat_out[31:29] inside {[3'h1:3'h4]})
      else $error("effective bus count out of range");
   AST_ONEHOT: assert property (rd_stat |-> $onehot(wb_dat_out[4:0]))
      else $error("station state is not one-hot");
   // an accepted arm consumes the configuration, so a second arm needs a new one
   AST_ARM_CFG: assert property (rd_stat && wb_dat_out[1] |-> !wb_dat_out[5])
      else $error("configuration not consumed by arming");
   AST_DONE_CAP: assert property (rd_stat && wb_dat_out[4] |-> wb_dat_out[6])
      else $error("done without a stored capture");
   AST_DEC_LIVE: assert property (rd_stat && $past(dec_now) == $past(dec_now, 2)
      |-> wb_dat_out[9:8] == $past(dec_now))
      else $error("decoder state field differs from the observation bus");
   AST_IRQ_FALL: assert property ($fell(irq_out) |-> $past(wb_cyc_in))
      else $error("interrupt dropped without a register access");
   AST_DAT_HOLD: assert property (!(wb_ack_out && !wb_we_in) |-> $stable(wb_dat_out))
      else $error("read data changed outside a read");
   cover property (rd_stat && wb_dat_out[4]);
   cover property ($rose(irq_out));
   cover property (rd_stat && wb_dat_out[7]);
endmodule // rsc_checker

bind rsc_capture_station rsc_checker chk (.clk_in(clk_in), .arst_n_in(arst_n_in),
   .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
   .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
   .rx_decoder_observe_bus_a_in(rx_decoder_observe_bus_a_in), .irq_out(irq_out));

// >>> test/rsc_host_model.sv
// host model: classic wishbone master issuing capture commands
module rsc_host_model (
   // clock
   input wire logic clk_in,
   // wishbone master
   output logic wb_cyc_out,
   output logic wb_stb_out,
   output logic wb_we_out,
   output logic [7:0] wb_adr_out,
   output logic [3:0] wb_sel_out,
   output logic [31:0] wb_dat_out,
   input wire logic [31:0] wb_dat_in,
   input wire logic wb_ack_in
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      wb_cyc_out = 1'b0;
      wb_stb_out = 1'b0;
      wb_we_out = 1'b0;
      wb_adr_out = 8'hFF;
      wb_sel_out = 4'h0;
      wb_dat_out = 32'h0000_0000;
   end
   // waits without limit; only the bench watchdog cuts a hang short
   task automatic access(input logic we, input logic [7:0] adr, input logic [31:0] wdat,
      output logic [31:0] rdat);
      @(posedge clk_in);
      wb_cyc_out <= 1'b1;
      wb_stb_out <= 1'b1;
      wb_we_out <= we;
      wb_adr_out <= adr;
      wb_sel_out <= 4'hF;
      wb_dat_out <= wdat;
      @(posedge clk_in);
      while (wb_ack_in !== 1'b1) @(posedge clk_in);
      rdat = wb_dat_in;
      wb_cyc_out <= 1'b0;
      wb_stb_out <= 1'b0;
      // released lines show no stale value
      wb_adr_out <= ~adr;
      wb_dat_out <= ~wdat;
   endtask
endmodule // rsc_host_model
